/* rtl/dsw_pkg.sv */
// dsw_pkg: constants, register map and carrier types of the drive state word block.
// assumes a 32-bit AHB-Lite register bus and one system clock.
package dsw_pkg;

  // register byte offsets
  localparam logic [7:0] DSW_OFS_STATE_WORD = 8'h00;
  localparam logic [7:0] DSW_OFS_SPEED_REF = 8'h04;
  localparam logic [7:0] DSW_OFS_MAX_FREQ = 8'h08;
  localparam logic [7:0] DSW_OFS_REF_FREQ = 8'h0C;
  localparam logic [7:0] DSW_OFS_ACT_FREQ = 8'h10;
  localparam logic [7:0] DSW_OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] DSW_OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] DSW_OFS_WARN_ACK = 8'h1C;

  // state word field positions
  localparam int DSW_BIT_QSTOP_N = 5;
  localparam int DSW_BIT_INHIBIT = 6;
  localparam int DSW_BIT_WARN = 7;
  localparam int DSW_BIT_IN_TOL = 8;
  localparam int DSW_BIT_CTRL_REQ = 9;
  localparam int DSW_BIT_REACHED = 10;
  localparam int DSW_RSVD_LO = 11;
  localparam int DSW_RSVD_HI = 15;
  localparam int DSW_WARN_ACK_BIT = 0;

  // widths
  localparam int DSW_WORD_W = 16;
  localparam int DSW_LOW_W = 5;
  localparam int DSW_REF_W = 19;
  localparam int DSW_SCALE_SHIFT = 14;
  localparam int DSW_IRQ_W = 4;

  // reference scaling points
  localparam logic [15:0] DSW_SPEED_ZERO = 16'h0000;
  localparam logic [15:0] DSW_SPEED_FULL_POS = 16'h4000;
  localparam logic [15:0] DSW_SPEED_FULL_NEG = 16'hC000;

  // reset values
  localparam logic [15:0] DSW_RST_SPEED_REF = 16'h0000;
  localparam logic [15:0] DSW_RST_MAX_FREQ = 16'h01F4;
  localparam logic [DSW_IRQ_W-1:0] DSW_RST_IRQ_MASK = 4'h0;
  localparam logic [DSW_WORD_W-1:0] DSW_RST_STATE_WORD = 16'h0000;

  // interrupt status bit positions
  localparam int DSW_IRQ_WARN = 0;
  localparam int DSW_IRQ_REACHED = 1;
  localparam int DSW_IRQ_CTRL_LOST = 2;
  localparam int DSW_IRQ_QSTOP = 3;

  // htrans code for a new transfer
  localparam logic [1:0] DSW_HTRANS_NONSEQ = 2'h2;

  // flags from the drive core state machine
  typedef struct packed {
    logic [DSW_LOW_W-1:0] low_bits;
    logic quick_stop_active;
    logic switch_on_inhibited;
    logic warning_present;
    logic speed_in_tolerance;
    logic fieldbus_has_control;
    logic control_local;
    logic control_other_if;
    logic control_supervisor;
  } dsw_drive_flags_t;

endpackage : dsw_pkg

/* rtl/dsw_freq_scale.sv */
// dsw_freq_scale: scales the signed speed reference word by the maximum frequency.
// assumes inputs come from registers on the same clock; one cycle of latency.
`timescale 1ns/1ps
`default_nettype none
module dsw_freq_scale
  import dsw_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // operands
  input wire logic [15:0] speed_reference_word,
  input wire logic [15:0] max_output_frequency,
  // result
  output logic signed [DSW_REF_W-1:0] ref_freq_ff
);

  logic signed [32:0] product;
  logic signed [DSW_REF_W-1:0] nxt_ref_freq;

  // signed word times unsigned max, then divide by 0x4000
  always_comb begin
    product = $signed(speed_reference_word) * $signed({1'b0, max_output_frequency});
    nxt_ref_freq = product[32:DSW_SCALE_SHIFT];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_freq_ff <= '0;
    end else begin
      ref_freq_ff <= nxt_ref_freq;
    end
  end

endmodule : dsw_freq_scale
`default_nettype wire

/* rtl/dsw_state_word.sv */
// dsw_state_word: drive operating state word bits 5..15 and speed reference scaling.
// assumes drive core flags and AHB-Lite master share hclk; single slave on the bus.
// Summary of operation
// - bit 5 low while quick-stop active
// - bit 6 high in switching-on-inhibited state
// - bit 7 holds warning until acknowledged
// - bit 8 high while speed within tolerance
// - bit 9 high when fieldbus controls drive
// - bit 9 low under local/other/supervisor control
// - bit 10 high when output reaches reference
// - reference equals word times max over 4000h
// - speed word signed: 4000h full, C000h negative
`timescale 1ns/1ps
`default_nettype none
module dsw_state_word
  import dsw_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // drive core
  input wire dsw_drive_flags_t drive_flags,
  input wire logic signed [15:0] actual_output_frequency,
  // outputs
  output logic [DSW_WORD_W-1:0] operating_state_word,
  output logic signed [DSW_REF_W-1:0] reference_frequency,
  output logic irq
);

  logic [DSW_WORD_W-1:0] word_ff;
  logic [DSW_WORD_W-1:0] nxt_word;
  logic [15:0] speed_ff;
  logic [15:0] max_ff;
  logic [DSW_IRQ_W-1:0] sts_ff;
  logic [DSW_IRQ_W-1:0] mask_ff;
  logic [DSW_IRQ_W-1:0] evt;
  logic warn_ff;
  logic nxt_warn;
  logic warn_ack;
  logic wr_pend_ff;
  logic [7:0] waddr_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] rd_mux;
  logic addr_ok;
  logic rd_take;
  logic wr_take;
  logic [16:0] abs_act;
  logic [DSW_REF_W-1:0] abs_ref;
  logic reached;
  logic ctrl_ok;
  logic signed [DSW_REF_W-1:0] ref_freq;
  logic word_vld_ff;

  // zero-wait slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign operating_state_word = word_ff;
  assign reference_frequency = ref_freq;
  assign irq = |(sts_ff & mask_ff);

  assign addr_ok = hsel && hready && htrans == DSW_HTRANS_NONSEQ;
  assign rd_take = addr_ok && !hwrite;
  assign wr_take = addr_ok && hwrite;
  assign warn_ack = wr_pend_ff && waddr_ff == DSW_OFS_WARN_ACK && hwdata[DSW_WARN_ACK_BIT];

  dsw_freq_scale u_scale (
    .hclk(hclk),
    .hresetn(hresetn),
    .speed_reference_word(speed_ff),
    .max_output_frequency(max_ff),
    .ref_freq_ff(ref_freq)
  );

  // magnitudes for the reached test, either direction
  always_comb begin
    abs_act = actual_output_frequency[15] ? 17'(-$signed({actual_output_frequency[15], actual_output_frequency}))
                                          : {1'b0, actual_output_frequency};
    abs_ref = ref_freq[DSW_REF_W-1] ? DSW_REF_W'(-ref_freq) : DSW_REF_W'(ref_freq);
    reached = {2'h0, abs_act} >= abs_ref;
    ctrl_ok = drive_flags.fieldbus_has_control && !(drive_flags.control_local ||
              drive_flags.control_other_if || drive_flags.control_supervisor);
  end

  // warning stays until acknowledged; a present warning wins over the ack
  always_comb begin
    nxt_warn = warn_ff;
    if (warn_ack) begin
      nxt_warn = 1'b0;
    end
    if (drive_flags.warning_present) begin
      nxt_warn = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      warn_ff <= 1'b0;
    end else begin
      warn_ff <= nxt_warn;
    end
  end

  // whole word built from one cycle of inputs
  always_comb begin
    nxt_word = '0;
    nxt_word[DSW_LOW_W-1:0] = drive_flags.low_bits;
    nxt_word[DSW_BIT_QSTOP_N] = !drive_flags.quick_stop_active;
    nxt_word[DSW_BIT_INHIBIT] = drive_flags.switch_on_inhibited;
    nxt_word[DSW_BIT_WARN] = nxt_warn;
    nxt_word[DSW_BIT_IN_TOL] = drive_flags.speed_in_tolerance;
    nxt_word[DSW_BIT_CTRL_REQ] = ctrl_ok;
    nxt_word[DSW_BIT_REACHED] = reached;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word_ff <= DSW_RST_STATE_WORD;
    end else begin
      word_ff <= nxt_word;
    end
  end

  // events: warning raised, reference reached, control lost, quick stop entered
  always_comb begin
    evt = '0;
    evt[DSW_IRQ_WARN] = nxt_word[DSW_BIT_WARN] && !word_ff[DSW_BIT_WARN];
    evt[DSW_IRQ_REACHED] = nxt_word[DSW_BIT_REACHED] && !word_ff[DSW_BIT_REACHED];
    evt[DSW_IRQ_CTRL_LOST] = !nxt_word[DSW_BIT_CTRL_REQ] && word_ff[DSW_BIT_CTRL_REQ];
    evt[DSW_IRQ_QSTOP] = !nxt_word[DSW_BIT_QSTOP_N] && word_ff[DSW_BIT_QSTOP_N];
    if (!word_vld_ff) begin
      evt = '0;
    end
  end

  // first word after reset is not an edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word_vld_ff <= 1'b0;
    end else begin
      word_vld_ff <= 1'b1;
    end
  end

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      waddr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= wr_take;
      waddr_ff <= haddr[7:0];
    end
  end

  // control registers written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed_ff <= DSW_RST_SPEED_REF;
      max_ff <= DSW_RST_MAX_FREQ;
      mask_ff <= DSW_RST_IRQ_MASK;
    end else if (wr_pend_ff) begin
      case (waddr_ff)
        DSW_OFS_SPEED_REF: begin
          speed_ff <= hwdata[15:0];
        end
        DSW_OFS_MAX_FREQ: begin
          max_ff <= hwdata[15:0];
        end
        DSW_OFS_IRQ_MASK: begin
          mask_ff <= hwdata[DSW_IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // sticky status, write one to clear, new event wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sts_ff <= '0;
    end else if (wr_pend_ff && waddr_ff == DSW_OFS_IRQ_STATUS) begin
      sts_ff <= (sts_ff & ~hwdata[DSW_IRQ_W-1:0]) | evt;
    end else begin
      sts_ff <= sts_ff | evt;
    end
  end

  // read mux sampled at the address phase
  always_comb begin
    case (haddr[7:0])
      DSW_OFS_STATE_WORD: rd_mux = {16'h0000, word_ff};
      DSW_OFS_SPEED_REF: rd_mux = {16'h0000, speed_ff};
      DSW_OFS_MAX_FREQ: rd_mux = {16'h0000, max_ff};
      DSW_OFS_REF_FREQ: rd_mux = 32'(ref_freq);
      DSW_OFS_ACT_FREQ: rd_mux = 32'(actual_output_frequency);
      DSW_OFS_IRQ_STATUS: rd_mux = {28'h0000000, sts_ff};
      DSW_OFS_IRQ_MASK: rd_mux = {28'h0000000, mask_ff};
      DSW_OFS_WARN_ACK: rd_mux = {31'h00000000, warn_ff};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h00000000;
    end else if (rd_take) begin
      hrdata_ff <= rd_mux;
    end
  end

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic signed [32:0] chk_prod;
  assign chk_prod = $signed(speed_ff) * $signed({1'b0, max_ff});

  AST_QSTOP: assert property (drive_flags.quick_stop_active |=> !word_ff[DSW_BIT_QSTOP_N] ##0
    !operating_state_word[DSW_BIT_QSTOP_N])
    else $error("quick stop not shown low in bit 5");
  AST_QSTOP_CLEAR: assert property (!drive_flags.quick_stop_active |=> word_ff[DSW_BIT_QSTOP_N])
    else $error("bit 5 low without quick stop");
  AST_INHIBIT: assert property (##1 word_ff[DSW_BIT_INHIBIT] == $past(drive_flags.switch_on_inhibited))
    else $error("bit 6 does not follow inhibited state");
  AST_WARN_SET: assert property (drive_flags.warning_present |=> word_ff[DSW_BIT_WARN] && warn_ff)
    else $error("warning not shown in bit 7");
  AST_WARN_HOLD: assert property (word_ff[DSW_BIT_WARN] && !warn_ack |=> word_ff[DSW_BIT_WARN])
    else $error("bit 7 dropped without acknowledge");
  AST_WARN_ACK: assert property (warn_ack && !drive_flags.warning_present |=> !word_ff[DSW_BIT_WARN])
    else $error("bit 7 kept after acknowledge");
  AST_TOL: assert property (drive_flags.speed_in_tolerance != word_ff[DSW_BIT_IN_TOL] |=>
    word_ff[DSW_BIT_IN_TOL] == $past(drive_flags.speed_in_tolerance))
    else $error("bit 8 does not follow tolerance");
  AST_CTRL: assert property (drive_flags.fieldbus_has_control && !drive_flags.control_local &&
    !drive_flags.control_other_if && !drive_flags.control_supervisor |=> word_ff[DSW_BIT_CTRL_REQ])
    else $error("bit 9 low under fieldbus control");
  AST_NOCTRL: assert property (drive_flags.control_local || drive_flags.control_other_if ||
    drive_flags.control_supervisor |=> !word_ff[DSW_BIT_CTRL_REQ])
    else $error("bit 9 high without fieldbus control");
  AST_REACHED: assert property ({2'h0, abs_act} >= abs_ref |=> word_ff[DSW_BIT_REACHED])
    else $error("bit 10 low with reference reached");
  AST_SCALE: assert property (##1 ref_freq == $past(chk_prod[32:DSW_SCALE_SHIFT]))
    else $error("reference frequency scaling wrong");
  AST_FULL_POS: assert property (speed_ff == DSW_SPEED_FULL_POS |=>
    ref_freq == $signed({3'b000, $past(max_ff)}))
    else $error("4000h does not give full positive");
  AST_FULL_NEG: assert property (speed_ff == DSW_SPEED_FULL_NEG |=>
    ref_freq == -$signed({3'b000, $past(max_ff)}))
    else $error("C000h does not give full negative");
  AST_ZERO: assert property (speed_ff == DSW_SPEED_ZERO |=> ref_freq == 0)
    else $error("zero word gives nonzero reference");
  AST_RSVD: assert property (operating_state_word[DSW_RSVD_HI:DSW_RSVD_LO] == 5'h00)
    else $error("reserved bits not zero");
  AST_COHERENT: assert property (rd_take && haddr[7:0] == DSW_OFS_STATE_WORD |=>
    hrdata == {16'h0000, $past(word_ff)})
    else $error("state word read not coherent");
  AST_IRQ: assert property (evt[DSW_IRQ_QSTOP] && mask_ff[DSW_IRQ_QSTOP] && !wr_pend_ff && !wr_take |=>
    irq [*2])
    else $error("enabled quick stop event lost");
  AST_NOT_REACHED: assert property ({2'h0, abs_act} < abs_ref |=> !word_ff[DSW_BIT_REACHED])
    else $error("bit 10 high below reference");
  AST_WARN_WINS: assert property (warn_ack && drive_flags.warning_present |=> word_ff[DSW_BIT_WARN])
    else $error("acknowledge cleared a present warning");
  AST_SPEED_WR: assert property (wr_pend_ff && waddr_ff == DSW_OFS_SPEED_REF |=>
    speed_ff == $past(hwdata[15:0]))
    else $error("speed reference write lost");
  AST_MAX_WR: assert property (wr_pend_ff && waddr_ff == DSW_OFS_MAX_FREQ |=>
    max_ff == $past(hwdata[15:0]))
    else $error("maximum frequency write lost");
  AST_REF_STABLE: assert property ($stable(speed_ff) && $stable(max_ff) |=> $stable(ref_freq))
    else $error("reference moved without an operand change");

  // interrupt status and register bus
  AST_EVT_SETS: assert property (evt != '0 |=> (sts_ff & $past(evt)) == $past(evt))
    else $error("event did not set its status bit");
  AST_STS_STICKY: assert property (!(wr_pend_ff && waddr_ff == DSW_OFS_IRQ_STATUS) |=>
    (sts_ff & $past(sts_ff)) == $past(sts_ff))
    else $error("status bit dropped without a clear");
  AST_W1C: assert property (wr_pend_ff && waddr_ff == DSW_OFS_IRQ_STATUS && evt == '0 |=>
    (sts_ff & $past(hwdata[DSW_IRQ_W-1:0])) == '0)
    else $error("written one did not clear status");
  AST_CTRL_EVT: assert property (word_ff[DSW_BIT_CTRL_REQ] && !nxt_word[DSW_BIT_CTRL_REQ] |=>
    sts_ff[DSW_IRQ_CTRL_LOST])
    else $error("loss of control not flagged");
  AST_MASK_WR: assert property (wr_pend_ff && waddr_ff == DSW_OFS_IRQ_MASK |=>
    mask_ff == $past(hwdata[DSW_IRQ_W-1:0]))
    else $error("mask write lost");
  AST_RD_UNMAPPED: assert property (rd_take && haddr[7:0] > DSW_OFS_WARN_ACK |=> hrdata == 32'h00000000)
    else $error("unmapped offset read nonzero");
  AST_HRDATA_HOLD: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data changed without a read");

  COV_WARN_ACK: cover property (word_ff[DSW_BIT_WARN] ##1 warn_ack ##1 !word_ff[DSW_BIT_WARN]);
  COV_REACHED: cover property (!word_ff[DSW_BIT_REACHED] ##1 word_ff[DSW_BIT_REACHED]);
  COV_NEG_REF: cover property (speed_ff == DSW_SPEED_FULL_NEG ##1 ref_freq < 0);
  COV_IRQ: cover property (!irq ##1 irq);
  COV_CTRL_LOST: cover property (evt[DSW_IRQ_CTRL_LOST] ##1 sts_ff[DSW_IRQ_CTRL_LOST]);

endmodule : dsw_state_word
`default_nettype wire

/* sim/dsw_ctrl_model.sv */
// dsw_ctrl_model: fieldbus controller stand-in, an ahb-lite master with one transfer task.
// assumes one slave whose hreadyout is wired back as hready; single word transfers only.
`timescale 1ns/1ps
`default_nettype none
module dsw_ctrl_model
  import dsw_pkg::*;
(
  // clock
  input wire logic hclk,
  // ahb-lite master side
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // address phase, then data phase; released data inverted
  task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    haddr <= {24'h000000, adr};
    hwrite <= wr;
    htrans <= DSW_HTRANS_NONSEQ;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wr ? wd : ~hwdata;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
    hwdata <= ~hwdata;
  endtask : xfer
endmodule : dsw_ctrl_model
`default_nettype wire

/* sim/drive_state_word_and_speed_ref_tb.sv */
// drive_state_word_and_speed_ref_tb: self-checking bench of the drive state word block.
// assumes the controller model as bus master and the bench as drive core.
`timescale 1ns/1ps
`default_nettype none
module drive_state_word_and_speed_ref_tb;
  import dsw_pkg::*;
  typedef struct packed {logic [12:0] f; logic [15:0] w;} dsw_row_t;
  logic hclk = 1'b0;
  logic hresetn;
  logic hsel, hwrite, hready, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  dsw_drive_flags_t drive_flags;
  logic signed [15:0] act;
  logic [15:0] word;
  logic signed [18:0] ref_f;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [15:0] spd [6] = '{16'h0000, 16'h4000, 16'hC000, 16'h2000, 16'hFFFF, 16'h7FFF};
  logic [15:0] mx [2] = '{16'h01F4, 16'hFFFF};
  dsw_row_t rows [9] = '{'{13'h0000, 16'h0420}, '{13'h0080, 16'h0400}, '{13'h0040, 16'h0460},
    '{13'h0010, 16'h0520}, '{13'h0008, 16'h0620}, '{13'h000C, 16'h0420}, '{13'h000A, 16'h0420},
    '{13'h0009, 16'h0420}, '{13'h1F00, 16'h043F}};

  always #2 hclk = ~hclk;

  dsw_ctrl_model u_ctrl (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));

  dsw_state_word u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .drive_flags(drive_flags), .actual_output_frequency(act),
    .operating_state_word(word), .reference_frequency(ref_f), .irq(irq));

  task automatic report_and_stop();
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_ctrl.xfer(1'b1, a, d, rdv);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    u_ctrl.xfer(1'b0, a, 32'h0, rdv);
    check(rdv, exp);
  endtask : rd_chk

  task automatic settle();
    repeat (3) @(posedge hclk);
    #1;
  endtask : settle

  task automatic flags(input logic [12:0] f);
    @(posedge hclk);
    drive_flags <= dsw_drive_flags_t'(f);
  endtask : flags

  task automatic set_act(input logic [15:0] v);
    @(posedge hclk);
    act <= v;
    settle();
  endtask : set_act

  function automatic logic [31:0] exp_ref(input logic [15:0] s, input logic [15:0] m);
    logic signed [33:0] p;
    p = ($signed(s) * $signed({1'b0, m})) >>> 14;
    return {{13{p[18]}}, p[18:0]};
  endfunction : exp_ref

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      report_and_stop();
    end
  end

  initial begin
    hresetn = 1'b0;
    drive_flags = '0;
    act = 16'h0000;
    repeat (10) @(posedge hclk);
    #1;
    check(word, 32'h0);
    check(irq, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(DSW_OFS_SPEED_REF, 32'h0);
    rd_chk(DSW_OFS_MAX_FREQ, 32'h01F4);
    rd_chk(DSW_OFS_IRQ_MASK, 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      flags(rows[i].f);
      settle();
      check(word, rows[i].w);
      rd_chk(DSW_OFS_STATE_WORD, rows[i].w);
    end
    $display("flag table test done");
    foreach (mx[j]) begin
      foreach (spd[k]) begin
        wr(DSW_OFS_MAX_FREQ, {16'h0, mx[j]});
        wr(DSW_OFS_SPEED_REF, {16'h0, spd[k]});
        settle();
        check(32'(ref_f), exp_ref(spd[k], mx[j]));
        rd_chk(DSW_OFS_REF_FREQ, exp_ref(spd[k], mx[j]));
      end
    end
    $display("scaling test done");
    wr(DSW_OFS_MAX_FREQ, 32'h01F4);
    wr(DSW_OFS_SPEED_REF, 32'h4000);
    set_act(16'd499);
    check(word[10], 32'h0);
    set_act(16'd500);
    check(word[10], 32'h1);
    set_act(-16'sd600);
    check(word[10], 32'h1);
    rd_chk(DSW_OFS_ACT_FREQ, 32'hFFFFFDA8);
    $display("reached test done");
    rd_chk(DSW_OFS_IRQ_STATUS, 32'hE);
    wr(DSW_OFS_IRQ_STATUS, 32'hF);
    wr(DSW_OFS_IRQ_MASK, 32'h1);
    settle();
    check(irq, 32'h0);
    flags(13'h0020);
    flags(13'h0000);
    settle();
    check(word[7], 32'h1);
    check(irq, 32'h1);
    rd_chk(DSW_OFS_WARN_ACK, 32'h1);
    wr(DSW_OFS_WARN_ACK, 32'h1);
    settle();
    check(word[7], 32'h0);
    wr(DSW_OFS_IRQ_STATUS, 32'h1);
    settle();
    check(irq, 32'h0);
    flags(13'h0080);
    settle();
    check(irq, 32'h0);
    rd_chk(DSW_OFS_IRQ_STATUS, 32'h8);
    wr(DSW_OFS_IRQ_MASK, 32'hF);
    settle();
    check(irq, 32'h1);
    $display("interrupt test done");
    wr(8'h20, 32'hFFFF);
    rd_chk(8'h20, 32'h0);
    wr(DSW_OFS_STATE_WORD, 32'hFFFF);
    rd_chk(DSW_OFS_STATE_WORD, 32'h0400);
    check(hresp, 32'h0);
    $display("access test done");
    @(posedge hclk);
    hresetn <= 1'b0;
    settle();
    check(word, 32'h0);
    check(32'(ref_f), 32'h0);
    check(irq, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(DSW_OFS_SPEED_REF, 32'h0);
    rd_chk(DSW_OFS_IRQ_MASK, 32'h0);
    rd_chk(DSW_OFS_IRQ_STATUS, 32'h0);
    settle();
    check(word, 32'h0400);
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule : drive_state_word_and_speed_ref_tb
`default_nettype wire
